/* hdl/smrc_pkg.sv */
// Constants shared by the supply monitor reset controller
package smrc_pkg;
  // Stop mode request encodings
  localparam logic [1:0] STOP_NONE    = 2'h0;
  localparam logic [1:0] STOP_SHALLOW = 2'h1;
  localparam logic [1:0] STOP_MIDDLE  = 2'h2;
  localparam logic [1:0] STOP_DEEPEST = 2'h3;
  // Reset status field positions
  localparam int unsigned RS_POWER_ON = 7;
  localparam int unsigned RS_LOWV     = 1;
  // Reset values
  localparam logic [7:0] RS_RESET_VAL = 8'h00;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage

/* hdl/smrc_sync.sv */
// Two-stage synchroniser for a group of asynchronous comparator levels
`timescale 1ns/100ps
module smrc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // First stage read only by second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // smrc_sync

/* hdl/smrc_top.sv */
// Supply monitor control: detect gating, reset hold, flags and reset status
`timescale 1ns/100ps
// Behaviour
// - Detect comparator active only with monitor enable; otherwise no reset or interrupt.
// - Detect trip level chosen by detect_level_select.
// - Stop modes disable detection unless stop_monitor_enable is set.
// - Both monitor enables set: refuse deepest and middle stop, allow shallow.
// - Power-on detector report asserts a reset condition.
// - After power-on, core held in reset until supply above low detect level.
// - Power-on reset sets power-on and low-voltage status flags.
// - Reset enable set: supply below selected level causes system reset.
// - After low-voltage reset, hold core until supply above selected level.
// - Low-voltage status flag set after low-voltage or power-on reset.
// - Low supply with enables and reset disabled sets flag and requests interrupt.
// - Warning flag sets when supply approaches detect level; never interrupts.
// - Warning trip level chosen by warning_level_select.
// - Reset status flags are read-only; a low-voltage reset sets its flag and keeps the power-on flag.
module smrc_top (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Analog comparator levels, asynchronous, high means supply below level
  input  wire logic       por_detect,
  input  wire logic       below_detect_high,
  input  wire logic       below_detect_low,
  input  wire logic       below_warn_high,
  input  wire logic       below_warn_low,
  // Control bits
  input  wire logic       monitor_enable_bit,
  input  wire logic       detect_level_select,
  input  wire logic       stop_monitor_enable,
  input  wire logic       lowv_reset_enable,
  input  wire logic       lowv_irq_enable,
  input  wire logic       warning_level_select,
  input  wire logic       lowv_flag_ack,
  // Stop mode request and other reset sources
  input  wire logic [1:0] stop_request,
  input  wire logic       other_reset_req,
  // Outputs
  output logic            core_reset,
  output logic [1:0]      stop_granted,
  output logic            lowv_flag,
  output logic            lowv_irq,
  output logic            supply_warning_flag,
  output logic            detector_active,
  output logic [7:0]      reset_status_reg
);
  typedef enum logic [1:0] {
    RUN_ST, HOLD_POR_ST, HOLD_LOWV_ST
  } smrc_state_type;

  smrc_state_type state;
  logic [4:0]     cmp_sync;
  logic           por_s, bdh_s, bdl_s, bwh_s, bwl_s;
  logic           in_stop;
  logic           det_on;
  logic           below_sel;
  logic           warn_sel;
  logic           lowv_reset_evt;
  logic           irq_evt;

  // Comparator synchronisation
  smrc_sync #(
    .WIDTH (5)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({por_detect, below_detect_high, below_detect_low,
                below_warn_high, below_warn_low}),
    .sync_out (cmp_sync)
  );

  assign {por_s, bdh_s, bdl_s, bwh_s, bwl_s} = cmp_sync;

  // Detector gating by enable and stop state
  assign in_stop   = (stop_granted != smrc_pkg::STOP_NONE);
  assign det_on    = monitor_enable_bit && (!in_stop || stop_monitor_enable);
  assign below_sel = detect_level_select ? bdh_s : bdl_s;
  assign warn_sel  = warning_level_select ? bwh_s : bwl_s;
  assign lowv_reset_evt = det_on && lowv_reset_enable && below_sel;
  assign irq_evt   = det_on && !lowv_reset_enable && below_sel;

  // Reset hold sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state      <= HOLD_POR_ST;
      core_reset <= 1'b1;
    end else begin
      case (state)
        RUN_ST: begin
          if (por_s) begin
            state      <= HOLD_POR_ST;
            core_reset <= 1'b1;
          end else if (lowv_reset_evt) begin
            state      <= HOLD_LOWV_ST;
            core_reset <= 1'b1;
          end else begin
            core_reset <= other_reset_req;
          end
        end
        HOLD_POR_ST: begin
          // Release only once above the low detect level
          if (!por_s && !bdl_s) begin
            state      <= RUN_ST;
            core_reset <= 1'b0;
          end
        end
        default: begin
          if (por_s) begin
            state <= HOLD_POR_ST;
          end else if (!below_sel) begin
            state      <= RUN_ST;
            core_reset <= 1'b0;
          end
        end
      endcase
    end
  end

  // Stop mode grant, deep modes refused while monitoring in stop
  always_ff @(posedge ref_clk) begin
    if (rst || core_reset) begin
      stop_granted <= smrc_pkg::STOP_NONE;
    end else if (stop_monitor_enable && monitor_enable_bit &&
                 stop_request != smrc_pkg::STOP_NONE) begin
      stop_granted <= smrc_pkg::STOP_SHALLOW;
    end else begin
      stop_granted <= stop_request;
    end
  end

  // Low-voltage flag and interrupt request, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst || core_reset) begin
      lowv_flag <= 1'b0;
      lowv_irq  <= 1'b0;
    end else begin
      lowv_flag <= irq_evt || (lowv_flag && !lowv_flag_ack);
      lowv_irq  <= lowv_irq_enable &&
                   (irq_evt || (lowv_flag && !lowv_flag_ack));
    end
  end

  // Warning flag, follows warning comparator while detector runs, no interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supply_warning_flag <= 1'b0;
    end else begin
      supply_warning_flag <= det_on && warn_sel;
    end
  end

  // Detector activity status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      detector_active <= 1'b0;
    end else begin
      detector_active <= det_on;
    end
  end

  // Reset cause status, no software write path
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_status_reg <= smrc_pkg::RS_RESET_VAL;
    end else if (por_s) begin
      // Power-on seen in run or in either hold state
      reset_status_reg <= smrc_pkg::RS_RESET_VAL;
      reset_status_reg[smrc_pkg::RS_POWER_ON] <= 1'b1;
      reset_status_reg[smrc_pkg::RS_LOWV]     <= 1'b1;
    end else if (state == RUN_ST && lowv_reset_evt) begin
      reset_status_reg[smrc_pkg::RS_LOWV] <= 1'b1;
      reset_status_reg[smrc_pkg::RS_POWER_ON] <= reset_status_reg[smrc_pkg::RS_POWER_ON];
    end else if (state == RUN_ST && other_reset_req && !core_reset) begin
      reset_status_reg <= smrc_pkg::RS_RESET_VAL;
    end
  end

  // Checks
  chk_por_holds_reset: assert property (@(posedge ref_clk) disable iff (rst)
    por_s |=> core_reset) else $error("power-on did not hold reset");
  chk_disabled_no_irq: assert property (@(posedge ref_clk) disable iff (rst)
    !monitor_enable_bit |=> !$rose(lowv_flag)) else $error("flag set while disabled");
  chk_stop_refused: assert property (@(posedge ref_clk) disable iff (rst)
    (stop_monitor_enable && monitor_enable_bit && !core_reset && stop_request != 2'h0)
    |=> stop_granted == 2'h1) else $error("deep stop granted");
  chk_lowv_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (state == RUN_ST && lowv_reset_evt && !por_s) |=> core_reset && state == HOLD_LOWV_ST)
    else $error("no low-voltage reset");
  chk_por_release: assert property (@(posedge ref_clk) disable iff (rst)
    (state == HOLD_POR_ST && bdl_s) |=> core_reset) else $error("released too early");
  chk_lowv_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state == HOLD_LOWV_ST && below_sel) |=> core_reset) else $error("left low hold");
  chk_flag_irq: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_evt && !core_reset) |=> lowv_flag ##0 (lowv_irq == $past(lowv_irq_enable)))
    else $error("flag or irq missing");
  chk_warn_no_irq: assert property (@(posedge ref_clk) disable iff (rst)
    (supply_warning_flag && !lowv_flag) |-> !lowv_irq) else $error("warning raised irq");
  chk_status_por: assert property (@(posedge ref_clk) disable iff (rst)
    (state == RUN_ST && por_s) |=> reset_status_reg[7] && reset_status_reg[1])
    else $error("status flags not set");
  cov_por_cycle: cover property (@(posedge ref_clk) state == HOLD_POR_ST ##1 state == RUN_ST);
  cov_lowv_reset: cover property (@(posedge ref_clk) state == HOLD_LOWV_ST);
  cov_lowv_irq: cover property (@(posedge ref_clk) $rose(lowv_irq));
  cov_stop_clamp: cover property (@(posedge ref_clk) stop_request == 2'h3 && stop_granted == 2'h1);
endmodule // smrc_top

/* verification/smrc_supply_model.sv */
// Behavioural supply comparators that face the monitor block
`timescale 1ns/100ps
module smrc_supply_model #(
  parameter logic [7:0] POR_LVL = 8'h0a,
  parameter logic [7:0] DET_LOW = 8'h1e,
  parameter logic [7:0] DET_HI  = 8'h28,
  parameter logic [7:0] WRN_LOW = 8'h32,
  parameter logic [7:0] WRN_HI  = 8'h3c
) (
  // Supply level in arbitrary steps
  input  wire logic [7:0] supply,
  // Comparator levels, high means supply below the trip point
  output logic            por_detect,
  output logic            below_detect_high,
  output logic            below_detect_low,
  output logic            below_warn_high,
  output logic            below_warn_low
);
  // Each comparator follows the supply with no hysteresis
  assign por_detect        = supply < POR_LVL;
  assign below_detect_low  = supply < DET_LOW;
  assign below_detect_high = supply < DET_HI;
  assign below_warn_low    = supply < WRN_LOW;
  assign below_warn_high   = supply < WRN_HI;
endmodule // smrc_supply_model

/* verification/test_supply_monitor_reset_ctrl.sv */
// Self-checking bench for the supply monitor reset controller
`timescale 1ns/100ps
module test_supply_monitor_reset_ctrl;
  typedef struct packed {logic m, ds, re, ie, ws; logic [7:0] sup; logic [3:0] exp;} smrc_row_type;
  logic         ref_clk, rst, por_detect, below_detect_high, below_detect_low;
  logic         below_warn_high, below_warn_low, monitor_enable_bit, detect_level_select;
  logic         stop_monitor_enable, lowv_reset_enable, lowv_irq_enable, warning_level_select;
  logic         lowv_flag_ack, other_reset_req, core_reset, lowv_flag, lowv_irq;
  logic         supply_warning_flag, detector_active;
  logic [1:0]   stop_request, stop_granted;
  logic [7:0]   supply, reset_status_reg;
  int           n_errors, checks;
  smrc_row_type rows [7];
  // Comparators and unit under test
  smrc_supply_model model (.supply, .por_detect, .below_detect_high, .below_detect_low,
    .below_warn_high, .below_warn_low);
  smrc_top uut (.ref_clk, .rst, .por_detect, .below_detect_high, .below_detect_low,
    .below_warn_high, .below_warn_low, .monitor_enable_bit, .detect_level_select,
    .stop_monitor_enable, .lowv_reset_enable, .lowv_irq_enable, .warning_level_select,
    .lowv_flag_ack, .stop_request, .other_reset_req, .core_reset, .stop_granted, .lowv_flag,
    .lowv_irq, .supply_warning_flag, .detector_active, .reset_status_reg);
  // Clock of 20 ns
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Step n edges, then move off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Compare and count
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst, lowv_flag_ack, other_reset_req, stop_monitor_enable, lowv_reset_enable} = 5'h10;
    {monitor_enable_bit, detect_level_select, lowv_irq_enable, warning_level_select} = 4'h0;
    {stop_request, supply, n_errors, checks} = '0;
    // Enables, supply, then expected core_reset, flag, irq, warning
    rows = '{'{1,0,0,1,0,8'h23,4'h1}, '{1,1,0,1,0,8'h23,4'h7}, '{1,1,0,0,0,8'h23,4'h5},
      '{0,1,1,1,0,8'h23,4'h0}, '{1,0,1,1,0,8'h19,4'h9}, '{1,0,0,1,1,8'h37,4'h1},
      '{1,0,0,1,0,8'h37,4'h0}};
    tick(10);
    rst = 1'b0;
    tick(4);
    chk("core_reset por", 8'h01, {7'h0, core_reset});
    supply = 8'h64;
    tick(6);
    chk("core_reset up", 8'h00, {7'h0, core_reset});
    chk("reset_status_reg", 8'h82, reset_status_reg);
    $display("power-on test done");
    foreach (rows[i]) begin
      {monitor_enable_bit, detect_level_select, lowv_reset_enable, lowv_irq_enable,
        warning_level_select, supply} = rows[i][16:4];
      tick(5);
      chk("reset flag irq warn", {4'h0, rows[i].exp},
        {4'h0, core_reset, lowv_flag, lowv_irq, supply_warning_flag});
      // Let the synchroniser drain before the ack, else the set wins
      supply = 8'h64;
      tick(3);
      lowv_flag_ack = 1'b1;
      tick(1);
      lowv_flag_ack = 1'b0;
      tick(3);
    end
    $display("table test done");
    {monitor_enable_bit, detect_level_select, lowv_reset_enable, supply} = {3'h7, 8'h23};
    tick(5);
    chk("core_reset lowv", 8'h01, {7'h0, core_reset});
    chk("status lowv", 8'h01, {7'h0, reset_status_reg[1]});
    supply = 8'h26;
    tick(5);
    chk("core_reset hold", 8'h01, {7'h0, core_reset});
    supply = 8'h2d;
    tick(5);
    chk("core_reset free", 8'h00, {7'h0, core_reset});
    $display("low-voltage reset test done");
    {lowv_reset_enable, stop_monitor_enable, stop_request} = 4'h7;
    tick(3);
    chk("stop_granted clamp", 8'h01, {6'h0, stop_granted});
    {stop_monitor_enable, supply} = {1'b0, 8'h23};
    tick(5);
    chk("stop_granted deep", 8'h03, {6'h0, stop_granted});
    chk("detector off", 8'h00, {6'h0, detector_active, lowv_flag});
    {stop_request, supply} = {2'h0, 8'h64};
    tick(3);
    chk("detector on", 8'h01, {7'h0, detector_active});
    $display("stop test done");
    other_reset_req = 1'b1;
    tick(3);
    chk("core_reset other", 8'h01, {7'h0, core_reset});
    chk("status other", 8'h00, reset_status_reg);
    other_reset_req = 1'b0;
    tick(6);
    $display("other reset test done");
    report_and_stop();
  end
  // Watchdog well past the expected run of a few microseconds
  initial begin
    #20000;
    n_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule // test_supply_monitor_reset_ctrl
